//--- inc/pin_cfg_pkg.sv
package pin_cfg_pkg;
  localparam int unsigned clk_hz = 100_000_000;
  localparam int unsigned burst_pulse_max_ms = 10;
  localparam int unsigned burst_pulse_cycles = burst_pulse_max_ms * (clk_hz / 1000);
  localparam logic [31:0] addr_pin1 = 32'h0000_0000;
  localparam logic [31:0] addr_pin4 = 32'h0000_0004;
  localparam logic [31:0] addr_pin3 = 32'h0000_0008;
  localparam logic [31:0] addr_kind = 32'h0000_000c;
  localparam logic [31:0] addr_duplex = 32'h0000_0010;
  localparam logic [31:0] addr_status = 32'h0000_0014;
  localparam logic [31:0] addr_env = 32'h0000_0018;
  localparam logic [4:0] pin3_max = 5'h12;
  localparam logic [2:0] pin14_max = 3'h4;
  localparam logic [4:0] pin_fn_reset = 5'h00;
  localparam logic [1:0] kind_reset = 2'h0;
  localparam logic [1:0] kind_unused = 2'h2;
  localparam logic [1:0] kind_max = 2'h2;
  localparam logic [6:0] fill_threshold_pct = 7'h50;
  localparam logic [8:0] dir_threshold_deg = 9'h0aa;
  typedef enum logic [4:0] {
    fn_unused = 5'b00000, fn_ain = 5'b00001, fn_readback = 5'b00010, fn_aout = 5'b00011,
    fn_ext_id = 5'b00100, fn_fill_flag = 5'b00101, fn_out_low = 5'b00110, fn_out_high = 5'b00111,
    fn_heat_hi = 5'b01000, fn_heat_lo = 5'b01001, fn_heat_hi_pu = 5'b01010, fn_heat_lo_pd = 5'b01011,
    fn_heat_hi_pd = 5'b01100, fn_heat_lo_pu = 5'b01101, fn_trig_single = 5'b01110,
    fn_trig_cont = 5'b01111, fn_burst_high = 5'b10000, fn_burst_low = 5'b10001, fn_dir_flag = 5'b10010
  } pin_fn_e;
  typedef struct packed {
    logic pin1_ain;
    logic pin4_ain;
    logic pin3_ain;
    logic pin1_readback;
    logic pin4_readback;
    logic speed_aout_en;
    logic dir_aout_en;
    logic temp_aout_en;
    logic aout_calc_en;
    logic heat_en;
    logic pull_up;
    logic pull_down;
  } pin_ctl_s;
endpackage

//--- verif/pin_cfg_assertions.sv
`timescale 1ns/100ps
module pin_cfg_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire pin_cfg_pkg::pin_ctl_s pin_ctl,
  input wire logic pin1_in,
  input wire logic pin4_in,
  input wire logic pin3_multi_io_in,
  input wire logic measure_busy,
  input wire logic [2:0] external_id_bit,
  input wire logic external_id_valid,
  input wire logic meas_start,
  input wire logic cont_start,
  input wire logic burst_start
);
  import pin_cfg_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  setup_answer_a: assert property (psel && !penable |=> pready) else $error("setup not answered");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  pull_excl_a: assert property (!(pin_ctl.pull_up && pin_ctl.pull_down)) else $error("both pulls on");
  id_follow_a: assert property (external_id_valid |-> external_id_bit ==
    $past({pin3_multi_io_in, pin4_in, pin1_in})) else $error("id bits not from pins");
  meas_pulse_a: assert property (meas_start |=> !meas_start) else $error("measure start held");
  cont_pulse_a: assert property (cont_start |=> !cont_start) else $error("continuous start held");
  burst_gap_a: assert property (burst_start |=> !burst_start) else $error("burst start held");
  burst_idle_a: assert property (burst_start |-> !$past(measure_busy)) else $error("burst while busy");
endmodule

//--- verif/pin_env_model.sv
`timescale 1ns/100ps
module pin_env_model (
  input wire logic pclk,
  input wire logic drv_en,
  input wire logic drv_val,
  input wire logic oe,
  input wire logic out,
  input wire logic pull_up,
  input wire logic pull_down,
  output logic level
);
  logic flip_r = 1'h0;
  // an open line with no pull wanders each cycle
  always @(posedge pclk) flip_r <= ~flip_r;
  assign level = oe ? out : drv_en ? drv_val : pull_up ? 1'h1 : pull_down ? 1'h0 : flip_r;
endmodule

//--- verif/tb_multifunction_pin_config.sv
`timescale 1ns/100ps
module tb_multifunction_pin_config;
  import pin_cfg_pkg::*;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, pin1_in = '0, pin4_in = '0;
  logic measure_busy = '0, drv_en = '0, drv_val = '0, pready, pslverr, err_v, hit;
  logic pin3_multi_io_in, pin3_multi_io_out, pin3_multi_io_oe, meas_start, cont_start, burst_start;
  logic external_id_valid;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd_v;
  logic [31:0] regs [5] = '{addr_pin1, addr_pin4, addr_pin3, addr_kind, addr_duplex};
  logic [6:0] avg_fill_pct = '0;
  logic [6:0] fills [3] = '{7'h50, 7'h51, 7'h00};
  logic [8:0] wind_dir_deg = '0;
  logic [2:0] external_id_bit, starts;
  pin_ctl_s pin_ctl;
  int mismatches = 0, n_checks = 0, cycles = 0;
  assign starts = {burst_start, cont_start, meas_start};
  always #5 pclk = ~pclk;
  multifunction_pin_config u_multifunction_pin_config (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin1_in, .pin4_in, .pin3_multi_io_in, .pin3_multi_io_out,
    .pin3_multi_io_oe, .avg_fill_pct, .wind_dir_deg, .measure_busy, .pin_ctl, .external_id_bit,
    .external_id_valid, .meas_start, .cont_start, .burst_start);
  pin_env_model u_pin_env_model (.pclk, .drv_en, .drv_val, .oe(pin3_multi_io_oe), .out(pin3_multi_io_out),
    .pull_up(pin_ctl.pull_up), .pull_down(pin_ctl.pull_down), .level(pin3_multi_io_in));
  task automatic print_verdict;
    if (mismatches == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e, input string n);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd_v = prdata;
    err_v = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic rd(input logic [31:0] a, e);
    apb(1'h0, a, '0);
    chk(rd_v, e, "rdata");
  endtask
  task automatic st;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic fire(input logic [4:0] m, input logic en, lv, input int k, input logic e);
    @(posedge pclk);
    {drv_en, drv_val} <= {en, ~lv};
    apb(1'h1, addr_pin3, {27'h0, m});
    st;
    @(posedge pclk);
    drv_val <= lv;
    hit = 1'h0;
    repeat (8) begin
      @(posedge pclk);
      hit |= starts[k];
    end
    chk(hit, e, "start");
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    foreach (regs[i]) rd(regs[i], '0);
    apb(1'h1, addr_pin1, 32'h5);
    rd(addr_pin1, '0);
    apb(1'h1, addr_pin3, 32'h2);
    apb(1'h1, addr_pin3, 32'h13);
    rd(addr_pin3, '0);
    apb(1'h0, 32'h1c, '0);
    chk(err_v, 1'h1, "pslverr");
    apb(1'h1, addr_pin1, 32'h1);
    apb(1'h1, addr_pin4, 32'h3);
    st;
    chk({pin_ctl.pin1_ain, pin_ctl.speed_aout_en, pin_ctl.dir_aout_en}, 3'h5, "ain");
    apb(1'h1, addr_pin1, 32'h2);
    apb(1'h1, addr_pin3, 32'h3);
    st;
    chk({pin_ctl.pin1_readback, pin_ctl.temp_aout_en}, 2'h3, "aout");
    apb(1'h1, addr_duplex, 32'h1);
    apb(1'h1, addr_pin1, '0);
    rd(addr_pin1, 32'h2);
    for (int v = 6; v < 8; v++) begin
      apb(1'h1, addr_pin3, 32'(v));
      st;
      chk({pin3_multi_io_oe, pin3_multi_io_out}, {1'h1, v[0]}, "drive");
    end
    apb(1'h1, addr_duplex, '0);
    apb(1'h1, addr_pin3, 32'h12);
    for (int d = 169; d < 171; d++) begin
      @(posedge pclk);
      wind_dir_deg <= 9'(d);
      st;
      chk(pin3_multi_io_out, d == 169, "dir");
    end
    apb(1'h1, addr_pin3, 32'h5);
    foreach (fills[i]) begin
      @(posedge pclk);
      avg_fill_pct <= fills[i];
      st;
      chk(pin3_multi_io_out, i > 0, "fill");
    end
    for (int v = 8; v < 14; v++) begin
      apb(1'h1, addr_pin3, 32'(v));
      for (int l = 0; l < 2; l++) begin
        @(posedge pclk);
        {drv_en, drv_val} <= {1'h1, l[0]};
        st;
        chk({pin_ctl.heat_en, pin_ctl.pull_up, pin_ctl.pull_down},
          {l[0] ^ v[0], v == 10 || v == 13, v == 11 || v == 12}, "heat");
      end
    end
    fire(5'h0e, 1'h1, 1'h1, 0, 1'h1);
    fire(5'h0f, 1'h1, 1'h1, 1, 1'h1);
    fire(5'h10, 1'h1, 1'h1, 2, 1'h1);
    fire(5'h10, 1'h0, 1'h1, 2, 1'h0);
    fire(5'h11, 1'h1, 1'h0, 2, 1'h1);
    fire(5'h11, 1'h0, 1'h0, 2, 1'h0);
    @(posedge pclk);
    {pin1_in, drv_en, drv_val} <= 3'h7;
    foreach (regs[i]) if (i < 3) apb(1'h1, regs[i], 32'h4);
    st;
    chk({external_id_valid, external_id_bit}, 4'hd, "id");
    foreach (regs[i]) if (i < 3) apb(1'h1, regs[i], '0);
    apb(1'h1, addr_kind, 32'h2);
    st;
    chk({pin_ctl.aout_calc_en, pin_ctl.pin1_ain, pin_ctl.pin4_ain}, '0, "calc");
    rd(addr_kind, 32'h2);
    apb(1'h1, addr_pin3, 32'h1);
    st;
    chk({pin_ctl.pin3_ain, pin_ctl.aout_calc_en}, 2'h3, "pin3 ain");
    print_verdict;
  end
endmodule
bind multifunction_pin_config pin_cfg_assertions u_pin_cfg_assertions (.pclk, .presetn, .psel, .penable,
  .pready, .pin_ctl, .pin1_in, .pin4_in, .pin3_multi_io_in, .measure_busy, .external_id_bit,
  .external_id_valid, .meas_start, .cont_start, .burst_start);

//--- verilog/multifunction_pin_config.sv
// Overview of operation
// - pin1/pin4 settings change only in half duplex
// - value 0 leaves the pin unused
// - value 1 samples analog input, disables output
// - value 2 reads back own voltage output in kind 0
// - value 3 drives analog output unless kind 2
// - value 4 on all three pins makes them external id bits
// - pin1/pin4 accept 0..4, reset 0
// - pin3 setting changes in either duplex mode
// - pin3 value 1 samples 16-bit analog input
// - pin3 value 3 outputs temperature unless kind 2
// - pin3 value 5 high once buffer over 80%
// - values 6 and 7 drive constant low/high
// - values 8 and 9 gate heating by level
// - 10..13 add pull-up or pull-down to heating
// - value 14 starts measurement on rising edge
// - value 15 starts continuous measurement on rising edge
// - burst high mode: pull-down, burst on high level
// - value 17: pull-up, burst on low level
// - value 18 high below 170 degrees
// - pin3 accepts 0..18 except 2, reset 0
// - kind 2 and all zero stops calculation
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
module multifunction_pin_config (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin1_in,
  input wire logic pin4_in,
  input wire logic pin3_multi_io_in,
  output logic pin3_multi_io_out,
  output logic pin3_multi_io_oe,
  input wire logic [6:0] avg_fill_pct,
  input wire logic [8:0] wind_dir_deg,
  input wire logic measure_busy,
  output pin_cfg_pkg::pin_ctl_s pin_ctl,
  output logic [2:0] external_id_bit,
  output logic external_id_valid,
  output logic meas_start,
  output logic cont_start,
  output logic burst_start
);
  import pin_cfg_pkg::*;

  logic [2:0] pin1_function_r;
  logic [2:0] pin4_function_r;
  logic [4:0] pin3_function_r;
  logic [1:0] output_kind_select_r;
  logic duplex_setting_r;
  logic fill_seen_r;
  logic pin3_prev_r;
  logic [31:0] prdata_nxt;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic pin3_ok;
  logic kind_ok;
  logic p14_ok;
  logic half_duplex;
  logic [4:0] p1;
  logic [4:0] p4;
  logic [4:0] p3;
  logic heat_active_high;
  logic heat_mode;
  pin_ctl_s ctl_nxt;

  assign half_duplex = ~duplex_setting_r;
  assign p1 = {2'h0, pin1_function_r};
  assign p4 = {2'h0, pin4_function_r};
  assign p3 = pin3_function_r;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_ok = (paddr == addr_pin1) | (paddr == addr_pin4) | (paddr == addr_pin3) |
                   (paddr == addr_kind) | (paddr == addr_duplex) | (paddr == addr_status) |
                   (paddr == addr_env);
  assign pin3_ok = (pwdata[31:5] == 27'h0) & (pwdata[4:0] <= pin3_max) & (pwdata[4:0] != fn_readback);
  assign p14_ok = (pwdata[31:3] == 29'h0) & (pwdata[2:0] <= pin14_max);
  assign kind_ok = (pwdata[31:2] == 30'h0) & (pwdata[1:0] <= kind_max);

  // apb slave answers with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata <= (psel & ~penable & ~pwrite) ? prdata_nxt : 32'h0000_0000;
    end
  end

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    case (paddr)
      addr_pin1: prdata_nxt = {29'h0, pin1_function_r};
      addr_pin4: prdata_nxt = {29'h0, pin4_function_r};
      addr_pin3: prdata_nxt = {27'h0, pin3_function_r};
      addr_kind: prdata_nxt = {30'h0, output_kind_select_r};
      addr_duplex: prdata_nxt = {31'h0, duplex_setting_r};
      addr_status: prdata_nxt = {28'h0, fill_seen_r, external_id_valid, pin3_multi_io_out, pin3_multi_io_oe};
      addr_env: prdata_nxt = {16'h0, measure_busy, avg_fill_pct, external_id_bit, pin3_multi_io_in,
                              pin4_in, pin1_in, 2'h0};
      default: prdata_nxt = 32'h0000_0000;
    endcase
  end

  // writes take effect at the access edge (pready high there)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin1_function_r <= pin_fn_reset[2:0];
      pin4_function_r <= pin_fn_reset[2:0];
    end else if (wr_en && pready && half_duplex && p14_ok) begin
      if (paddr == addr_pin1) pin1_function_r <= pwdata[2:0];
      if (paddr == addr_pin4) pin4_function_r <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin3_function_r <= pin_fn_reset;
    end else if (wr_en && pready && paddr == addr_pin3 && pin3_ok) begin
      pin3_function_r <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_kind_select_r <= kind_reset;
      duplex_setting_r <= 1'b0;
    end else if (wr_en && pready) begin
      if (paddr == addr_kind && kind_ok && half_duplex) output_kind_select_r <= pwdata[1:0];
      if (paddr == addr_duplex && pwdata[31:1] == 31'h0) duplex_setting_r <= pwdata[0];
    end
  end

  // sticky after first fill above threshold since start-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fill_seen_r <= 1'b0;
    else if (avg_fill_pct > fill_threshold_pct) fill_seen_r <= 1'b1;
  end

  assign heat_mode = (p3 >= fn_heat_hi) && (p3 <= fn_heat_lo_pu);
  assign heat_active_high = (p3 == fn_heat_hi) || (p3 == fn_heat_hi_pu) || (p3 == fn_heat_hi_pd);

  always_comb begin
    ctl_nxt = '0;
    ctl_nxt.pin1_ain = (p1 == fn_ain);
    ctl_nxt.pin4_ain = (p4 == fn_ain);
    ctl_nxt.pin3_ain = (p3 == fn_ain);
    ctl_nxt.pin1_readback = (p1 == fn_readback) && (output_kind_select_r == kind_reset);
    ctl_nxt.pin4_readback = (p4 == fn_readback) && (output_kind_select_r == kind_reset);
    ctl_nxt.speed_aout_en = (p1 == fn_aout) && (output_kind_select_r != kind_unused);
    ctl_nxt.dir_aout_en = (p4 == fn_aout) && (output_kind_select_r != kind_unused);
    ctl_nxt.temp_aout_en = (p3 == fn_aout) && (output_kind_select_r != kind_unused);
    ctl_nxt.aout_calc_en = !((output_kind_select_r == kind_unused) && p1 == fn_unused &&
                             p4 == fn_unused && p3 == fn_unused);
    ctl_nxt.heat_en = heat_mode && (heat_active_high ? pin3_multi_io_in : ~pin3_multi_io_in);
    ctl_nxt.pull_up = (p3 == fn_heat_hi_pu) || (p3 == fn_heat_lo_pu) || (p3 == fn_burst_low);
    ctl_nxt.pull_down = (p3 == fn_heat_lo_pd) || (p3 == fn_heat_hi_pd) || (p3 == fn_burst_high);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_ctl <= '0;
    else pin_ctl <= ctl_nxt;
  end

  // pin3 digital output drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin3_multi_io_out <= 1'b0;
      pin3_multi_io_oe <= 1'b0;
    end else begin
      case (p3)
        fn_fill_flag: begin
          pin3_multi_io_oe <= 1'b1;
          pin3_multi_io_out <= fill_seen_r;
        end
        fn_out_low: begin
          pin3_multi_io_oe <= 1'b1;
          pin3_multi_io_out <= 1'b0;
        end
        fn_out_high: begin
          pin3_multi_io_oe <= 1'b1;
          pin3_multi_io_out <= 1'b1;
        end
        fn_dir_flag: begin
          pin3_multi_io_oe <= 1'b1;
          pin3_multi_io_out <= (wind_dir_deg < dir_threshold_deg);
        end
        default: begin
          pin3_multi_io_oe <= 1'b0;
          pin3_multi_io_out <= 1'b0;
        end
      endcase
    end
  end

  // external id: all three pins must be set to the id function
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_id_bit <= 3'h0;
      external_id_valid <= 1'b0;
    end else begin
      external_id_valid <= (p1 == fn_ext_id) && (p4 == fn_ext_id) && (p3 == fn_ext_id);
      external_id_bit <= {pin3_multi_io_in, pin4_in, pin1_in};
    end
  end

  // measurement triggers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin3_prev_r <= 1'b0;
    else pin3_prev_r <= pin3_multi_io_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_start <= 1'b0;
      cont_start <= 1'b0;
      burst_start <= 1'b0;
    end else begin
      meas_start <= (p3 == fn_trig_single) && pin3_multi_io_in && !pin3_prev_r;
      cont_start <= (p3 == fn_trig_cont) && pin3_multi_io_in && !pin3_prev_r;
      // level-started burst restarts whenever the previous one is over
      burst_start <= !measure_busy && !burst_start &&
                     (((p3 == fn_burst_high) && pin3_multi_io_in) ||
                      ((p3 == fn_burst_low) && !pin3_multi_io_in));
    end
  end
endmodule
